// ==== exec_cfg.svh ====
// Addresses, instruction fields, flag positions and codes of the execution unit
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define A_INSTR 16'h0000
`define A_FLAGS 16'h0004
`define A_STATE 16'h0008
`define F_WBANK 15:6
`define W_REGION 10'h001
`define F_WIDX 5:2
`define MEM_SEL 15
`define F_MIDX 13:2
`define F_OP5 23:19
`define F_OP9 23:15
`define OPC_SUMC 5'h09
`define OPC_ANDW 5'h0C
`define OPC_ANDF 9'h16C
`define OPC_ANDL 9'h164
`define F_W 18:15
`define F_B 14
`define F_DST 13
`define F_Q 13:11
`define F_D 10:7
`define F_P 6:4
`define F_S 3:0
`define F_MARK 6:5
`define FIVE_BIT_CONSTANT_MARK 2'h3
`define F_K5 4:0
`define F_K10 13:4
`define F_FILE 12:0
`define ACC_REG 4'h0
`define FLG_C 0
`define FLG_Z 1
`define FLG_SOV 2
`define FLG_N 3
`define FLG_HALF 8
`define FLG_MASK 16'h010F
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002
`define RST_W 16'h0000
`define RST_IR 24'h000000
`define RESP_OKAY 1'b0
`endif

// ==== exec_pkg.sv ====
// Types shared by the execution unit
package exec_pkg;
  typedef enum logic [2:0] {
    AM_DIR = 3'h0,
    AM_IND = 3'h1,
    AM_PDEC = 3'h2,
    AM_PINC = 3'h3,
    AM_PRDEC = 3'h4,
    AM_PRINC = 3'h5
  } amode_t;
  typedef enum {FM_NONE, FM_SUMC, FM_ANDW, FM_ANDF, FM_ANDL} form_t;
  typedef enum {EX_IDLE, EX_DEC, EX_OPR} ex_t;
  typedef enum {B_IDLE, B_ACT, B_RD} bus_t;
endpackage

// ==== mem_bus.sv ====
// Memory port bundle between the execution unit and its data store
`timescale 1ns/1ps
interface mem_bus;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [1:0] be;
  logic we;
  logic [15:0] rdata;
  modport user(output addr, output wdata, output be, output we,
    input rdata);
  modport store(input addr, input wdata, input be, input we,
    output rdata);
endinterface

// ==== data_mem.sv ====
// Byte-writable data memory with a registered read port
`timescale 1ns/1ps
module data_mem #(
  parameter int WORDS = 4096
) (
  input wire logic clk,
  mem_bus.store port
);
  logic [15:0] cells [WORDS];

  // Read data always lags the address by one clock
  always_ff @(posedge clk) begin
    if (port.we && port.be[0]) begin
      cells[port.addr][7:0] <= port.wdata[7:0];
    end
    if (port.we && port.be[1]) begin
      cells[port.addr][15:8] <= port.wdata[15:8];
    end
    port.rdata <= cells[port.addr];
  end
endmodule

// ==== carry_and_exec.sv ====
// Add-with-carry and AND execution unit with AHB-Lite register access
//////////////////////////////////////////////////////////////////////////////
// Function
// - The register add-with-carry (prefix 0100 1) sums base, source and carry into the destination.
// - Add-with-carry may clear the zero flag but never set it.
// - The size bit picks word operation at 0 and byte operation at 1.
// - The q field gives the destination mode and the p field the source mode, incl. pointer update forms.
// - The w, d and s fields each name one of sixteen working registers.
// - The file form (1011 0110 0) ANDs the file register with the default accumulator.
// - In the file form the destination bit sends the result to the accumulator at 0 and the file at 1.
// - The default accumulator is working register zero.
// - The file form carries a 13-bit file address, 0 to 8191.
// - The literal form (1011 0010) ANDs a 10-bit constant into the named register.
// - The short literal form, marked by two ones, ANDs the base with a 5-bit unsigned constant.
// - The register AND form ANDs source and base into the destination, source from p and s.
//////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "exec_cfg.svh"
module carry_and_exec
  import exec_pkg::*;
#(
  parameter int MEM_WORDS = 4096
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  logic [15:0] default_accumulator_register [16];
  logic [15:0] next_default_accumulator_register [16];
  logic [15:0] flags, next_flags;
  logic [23:0] ir, next_ir;
  logic badOp, next_badOp;
  ex_t exState, next_exState;
  bus_t bState, next_bState;
  logic [15:0] aAddr, next_aAddr;
  logic aWrite, next_aWrite;
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  form_t form;
  logic b, isLit5, dBit, srcMem, dstMem, isAnd, zero, msb, ovf, legal;
  logic busGo;
  logic [3:0] wNum, dNum, sNum, dReg;
  logic [2:0] q, p;
  logic [15:0] opA, opB, srcEA, dstEA, res;
  logic [16:0] sumW;
  logic [8:0] sumB;
  logic [4:0] sumN;

  mem_bus mb();

  data_mem #(.WORDS(MEM_WORDS)) u_mem (
    .clk(clk),
    .port(mb.store)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic form_t formOf(logic [23:0] i);
    form_t f;
    f = FM_NONE;
    if (i[`F_OP5] == `OPC_SUMC) f = FM_SUMC;
    else if (i[`F_OP5] == `OPC_ANDW) f = FM_ANDW;
    else if (i[`F_OP9] == `OPC_ANDF) f = FM_ANDF;
    else if (i[`F_OP9] == `OPC_ANDL) f = FM_ANDL;
    return f;
  endfunction

  function automatic logic [15:0] stepOf(logic bb);
    return bb ? `STEP_BYTE : `STEP_WORD;
  endfunction

  // Address used for the access: pre-modes move first
  function automatic logic [15:0] eaOf(logic [2:0] m, logic [15:0] r,
      logic bb);
    logic [15:0] e;
    e = r;
    if (m == AM_PRDEC) e = r - stepOf(bb);
    else if (m == AM_PRINC) e = r + stepOf(bb);
    return e;
  endfunction

  // Pointer value left behind after the access
  function automatic logic [15:0] ptrOf(logic [2:0] m, logic [15:0] r,
      logic bb);
    logic [15:0] e;
    e = r;
    if (m == AM_PDEC || m == AM_PRDEC) e = r - stepOf(bb);
    else if (m == AM_PINC || m == AM_PRINC) e = r + stepOf(bb);
    return e;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    form = formOf(ir);
    b = ir[`F_B];
    wNum = ir[`F_W];
    q = ir[`F_Q];
    dNum = ir[`F_D];
    p = ir[`F_P];
    sNum = ir[`F_S];
    dBit = ir[`F_DST];
    isLit5 = (ir[`F_MARK] == `FIVE_BIT_CONSTANT_MARK);
    srcEA = eaOf(p, default_accumulator_register[sNum], b);
    dstEA = eaOf(q, default_accumulator_register[dNum], b);
    srcMem = 1'b0;
    dstMem = 1'b0;
    opA = default_accumulator_register[wNum];
    opB = default_accumulator_register[sNum];
    dReg = dNum;
    legal = 1'b1;
    unique case (form)
      FM_ANDF: begin
        srcEA = {3'h0, ir[`F_FILE]};
        dstEA = srcEA;
        srcMem = 1'b1;
        dstMem = dBit;
        opA = default_accumulator_register[`ACC_REG];
        dReg = `ACC_REG;
      end
      FM_ANDL: begin
        opA = default_accumulator_register[sNum];
        opB = {6'h00, ir[`F_K10]};
        dReg = sNum;
      end
      FM_SUMC, FM_ANDW: begin
        srcMem = !isLit5 && (p != AM_DIR);
        dstMem = (q != AM_DIR);
        if (isLit5) opB = {11'h000, ir[`F_K5]};
        // Codes 6 and 7 of a mode field are not decoded
        legal = (q <= AM_PRINC) && (isLit5 || p <= AM_PRINC);
      end
      FM_NONE: begin
        legal = 1'b0;
      end
    endcase
    if (srcMem) begin
      if (!b) opB = mb.rdata;
      else if (srcEA[0]) opB = {8'h00, mb.rdata[15:8]};
      else opB = {8'h00, mb.rdata[7:0]};
    end
    isAnd = (form != FM_SUMC);
    sumW = {1'b0, opA} + {1'b0, opB} + {16'h0000, flags[`FLG_C]};
    sumB = {1'b0, opA[7:0]} + {1'b0, opB[7:0]} + {8'h00, flags[`FLG_C]};
    sumN = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, flags[`FLG_C]};
    res = isAnd ? (opA & opB) : sumW[15:0];
    zero = b ? (res[7:0] == 8'h00) : (res == 16'h0000);
    msb = b ? res[7] : res[15];
    ovf = b ? (opA[7] == opB[7]) && (res[7] != opA[7])
            : (opA[15] == opB[15]) && (res[15] != opA[15]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Execution and register state; the bus only touches it while idle
  always_comb begin
    next_default_accumulator_register = default_accumulator_register;
    next_flags = flags;
    next_ir = ir;
    next_badOp = badOp;
    next_exState = exState;
    mb.addr = srcEA[12:1];
    mb.we = 1'b0;
    mb.be = 2'h0;
    mb.wdata = res;
    unique case (exState)
      EX_IDLE: begin
        if (busGo) begin
          mb.addr = aAddr[`F_MIDX];
          if (aWrite) begin
            if (aAddr == `A_INSTR) begin
              next_ir = hwdata[23:0];
              next_exState = EX_DEC;
            end else if (aAddr == `A_FLAGS) begin
              next_flags = hwdata[15:0] & `FLG_MASK;
            end else if (aAddr[`F_WBANK] == `W_REGION) begin
              next_default_accumulator_register[aAddr[`F_WIDX]] = hwdata[15:0];
            end else if (aAddr[`MEM_SEL]) begin
              mb.we = 1'b1;
              mb.be = 2'h3;
              mb.wdata = hwdata[15:0];
            end
          end
        end
      end
      EX_DEC: begin
        // Source operand read is in flight during this cycle
        next_badOp = !legal;
        next_exState = legal ? EX_OPR : EX_IDLE;
      end
      EX_OPR: begin
        next_exState = EX_IDLE;
        mb.addr = dstEA[12:1];
        if (form == FM_SUMC || form == FM_ANDW) begin
          if (srcMem) next_default_accumulator_register[sNum] = ptrOf(p, default_accumulator_register[sNum], b);
          if (dstMem) next_default_accumulator_register[dNum] = ptrOf(q, default_accumulator_register[dNum], b);
        end
        if (dstMem) begin
          mb.we = 1'b1;
          mb.be = !b ? 2'h3 : (dstEA[0] ? 2'h2 : 2'h1);
          mb.wdata = b ? {res[7:0], res[7:0]} : res;
        end else begin
          // Byte results leave the upper half of the register alone
          next_default_accumulator_register[dReg] = b ? {next_default_accumulator_register[dReg][15:8], res[7:0]} : res;
        end
        next_flags[`FLG_N] = msb;
        if (isAnd) begin
          next_flags[`FLG_Z] = zero;
        end else begin
          next_flags[`FLG_Z] = flags[`FLG_Z] & zero;
          next_flags[`FLG_C] = b ? sumB[8] : sumW[16];
          next_flags[`FLG_HALF] = b ? sumN[4] : sumB[8];
          next_flags[`FLG_SOV] = ovf;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        default_accumulator_register[i] <= `RST_W;
      end
      flags <= `RST_W;
      ir <= `RST_IR;
      badOp <= 1'b0;
      exState <= EX_IDLE;
    end else begin
      default_accumulator_register <= next_default_accumulator_register;
      flags <= next_flags;
      ir <= next_ir;
      badOp <= next_badOp;
      exState <= next_exState;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave; the data phase stalls until the unit is idle
  assign busGo = (bState == B_ACT) && (exState == EX_IDLE);

  always_comb begin
    next_bState = bState;
    next_aAddr = aAddr;
    next_aWrite = aWrite;
    next_hrdata = hrdata;
    next_hreadyout = hreadyout;
    unique case (bState)
      B_IDLE: begin
        if (hsel && hready && htrans[1]) begin
          next_aAddr = haddr[15:0];
          next_aWrite = hwrite;
          next_hreadyout = 1'b0;
          next_bState = B_ACT;
        end
      end
      B_ACT: begin
        if (exState == EX_IDLE) next_bState = B_RD;
      end
      B_RD: begin
        next_bState = B_IDLE;
        next_hreadyout = 1'b1;
        next_hrdata = 32'h00000000;
        if (!aWrite) begin
          if (aAddr == `A_INSTR) next_hrdata = {8'h00, ir};
          else if (aAddr == `A_FLAGS) next_hrdata = {16'h0000, flags};
          else if (aAddr == `A_STATE) next_hrdata = {31'h0, badOp};
          else if (aAddr[`F_WBANK] == `W_REGION)
            next_hrdata = {16'h0000, default_accumulator_register[aAddr[`F_WIDX]]};
          else if (aAddr[`MEM_SEL]) next_hrdata = {16'h0000, mb.rdata};
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bState <= B_IDLE;
      aAddr <= `RST_W;
      aWrite <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `RESP_OKAY;
    end else begin
      bState <= next_bState;
      aAddr <= next_aAddr;
      aWrite <= next_aWrite;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp <= `RESP_OKAY;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_cycle;
    exState == EX_DEC && legal |=> exState == EX_OPR ##1 exState == EX_IDLE;
  endproperty
  a_cycle: assert property (p_cycle) else $error("late finish");

  property p_accw;
    exState == EX_OPR && form == FM_ANDF && !dBit && !b
      |=> default_accumulator_register[0] == ($past(default_accumulator_register[0]) & $past(mb.rdata));
  endproperty
  a_accw: assert property (p_accw) else $error("acc result");

  property p_filew;
    exState == EX_OPR && form == FM_ANDF && dBit && !b
      |-> mb.we && mb.addr == ir[12:1] && mb.wdata == (default_accumulator_register[0] & mb.rdata);
  endproperty
  a_filew: assert property (p_filew) else $error("file dest");

  property p_zsticky;
    exState == EX_OPR && form == FM_SUMC
      |=> !flags[`FLG_Z] || $past(flags[`FLG_Z]);
  endproperty
  a_zsticky: assert property (p_zsticky) else $error("Z was set");

  property p_andkeep;
    exState == EX_OPR && isAnd |=> flags[`FLG_C] == $past(flags[`FLG_C])
      && flags[`FLG_SOV] == $past(flags[`FLG_SOV])
      && flags[`FLG_HALF] == $past(flags[`FLG_HALF])
      && flags[`FLG_N] == $past(msb);
  endproperty
  a_andkeep: assert property (p_andkeep) else $error("AND flags");

  property p_carry;
    exState == EX_OPR && form == FM_SUMC && !b && !isLit5 && p == AM_DIR
      && q == AM_DIR |=> {flags[`FLG_C], default_accumulator_register[$past(dNum)]} ==
      {1'b0, $past(opA)} + {1'b0, $past(opB)}
      + {16'h0000, $past(flags[`FLG_C])};
  endproperty
  a_carry: assert property (p_carry) else $error("sum wrong");

  property p_ten_bit_constant;
    exState == EX_OPR && form == FM_ANDL && !b
      |=> default_accumulator_register[$past(sNum)] == ($past(opA) & {6'h00, ir[`F_K10]});
  endproperty
  a_ten_bit_constant: assert property (p_ten_bit_constant) else $error("literal AND");

  property p_bytekeep;
    exState == EX_OPR && form == FM_ANDW && isLit5 && q == AM_DIR && b
      |=> default_accumulator_register[$past(dNum)][15:8] == $past(opB[15:8] | default_accumulator_register[dNum][15:8])
      && default_accumulator_register[$past(dNum)][7:0] == ($past(opA[7:0]) & {3'h0, ir[`F_K5]});
  endproperty
  a_bytekeep: assert property (p_bytekeep) else $error("byte op");

  property p_ptr;
    exState == EX_OPR && form == FM_ANDW && !isLit5 && p == AM_PINC
      && q == AM_DIR && dNum != sNum
      |=> default_accumulator_register[$past(sNum)] == $past(default_accumulator_register[sNum]) + stepOf($past(b))
      && default_accumulator_register[$past(dNum)] == ($past(b)
        ? {$past(default_accumulator_register[dNum][15:8]), $past(opA[7:0] & opB[7:0])}
        : $past(opA & opB));
  endproperty
  a_ptr: assert property (p_ptr) else $error("post-increment");
endmodule

// ==== ahb_host.sv ====
// Bus master model that issues single AHB-Lite word transfers
`timescale 1ns/1ps
module ahb_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Call just after a rising edge; hready is sampled at the edge itself
  task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk iff hready);
    htrans <= 2'h0;
    if (wr) begin
      hwdata <= d;
    end
    @(posedge clk iff hready);
    q = hrdata;
    // Stale write data must not look valid to the slave
    hwdata <= ~hwdata;
  endtask
endmodule

// ==== carry_and_exec_tb.sv ====
// Self-checking bench for the add-with-carry and AND execution unit
`timescale 1ns/1ps
`include "exec_cfg.svh"
module carry_and_exec_tb;
  logic clk;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  carry_and_exec uut (
    .clk(clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  ahb_host host (
    .clk(clk),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata)
  );

  always #10 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // About 90 transfers of at most 6 cycles each
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    tests_run++;
    if (q !== exp) begin
      num_errors++;
      $display("unexpected at %0t addr %h got %h want %h", $time, a, q, exp);
    end
    tests_run++;
    if (hresp !== `RESP_OKAY) begin
      num_errors++;
      $display("unexpected at %0t hresp %h want %h", $time, hresp,
        `RESP_OKAY);
    end
  endtask

  function automatic logic [31:0] wa(input int n);
    return 32'h40 + 32'(4 * n);
  endfunction

  // Even data byte address to its bus window address
  function automatic logic [31:0] dm(input int a);
    return 32'h8000 + 32'(2 * a);
  endfunction

  // Base register is always given in direct mode by this stimulus
  function automatic logic [31:0] ins(input logic [4:0] op,
      input int w, input int b, input int q, input int d, input int p,
      input int s);
    return {8'h0, op, w[3:0], b[0], q[2:0], d[3:0], p[2:0], s[3:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk(`A_FLAGS, 32'h0);
    chk(`A_STATE, 32'h0);
    chk(wa(5), 32'h0);
    wr(32'h100, 32'hFFFF);
    chk(32'h100, 32'h0);
  endtask

  task automatic s_carry_flags();
    wr(wa(1), 32'h7FFF);
    wr(wa(2), 32'h1);
    wr(`A_FLAGS, 32'h3);
    wr(`A_INSTR, ins(`OPC_SUMC, 1, 0, 0, 3, 0, 2));
    chk(wa(3), 32'h8001);
    chk(`A_FLAGS, 32'h10C);
    wr(wa(1), 32'hFFFF);
    wr(wa(2), 32'h0);
    wr(`A_FLAGS, 32'h1);
    wr(`A_INSTR, ins(`OPC_SUMC, 1, 0, 0, 3, 0, 2));
    chk(wa(3), 32'h0);
    chk(`A_FLAGS, 32'h101);
  endtask

  task automatic s_carry_byte();
    wr(wa(0), 32'hCC20);
    wr(wa(1), 32'h0800);
    wr(wa(2), 32'h1000);
    wr(dm(16'h0800), 32'hAB25);
    wr(dm(16'h1000), 32'hFFFF);
    wr(`A_FLAGS, 32'h1);
    wr(`A_INSTR, ins(`OPC_SUMC, 0, 1, 3, 2, 3, 1));
    chk(dm(16'h1000), 32'hFF46);
    chk(wa(1), 32'h0801);
    chk(wa(2), 32'h1001);
    chk(`A_FLAGS, 32'h0);
  endtask

  // Short literal 6 with a pre-decremented destination pointer
  task automatic s_carry_short();
    wr(wa(3), 32'h6006);
    wr(wa(4), 32'h1000);
    wr(`A_FLAGS, 32'h1);
    wr(`A_INSTR, ins(`OPC_SUMC, 3, 0, 4, 4, 6, 6));
    chk(dm(16'h0FFE), 32'h600D);
    chk(wa(4), 32'h0FFE);
    chk(`A_FLAGS, 32'h0);
  endtask

  task automatic s_illegal();
    wr(wa(3), 32'h5A5A);
    wr(`A_INSTR, ins(`OPC_SUMC, 1, 0, 6, 3, 0, 2));
    chk(`A_STATE, 32'h1);
    chk(wa(3), 32'h5A5A);
  endtask

  task automatic s_and_file();
    wr(wa(0), 32'hCC80);
    wr(dm(16'h0200), 32'h12C0);
    wr(`A_FLAGS, 32'h10D);
    wr(`A_INSTR, {8'h0, `OPC_ANDF, 1'b0, 1'b0, 13'h0200});
    chk(wa(0), 32'h0080);
    chk(dm(16'h0200), 32'h12C0);
    chk(`A_FLAGS, 32'h105);
    chk(`A_STATE, 32'h0);
    wr(dm(16'h1FFE), 32'hF0F0);
    wr(`A_INSTR, {8'h0, `OPC_ANDF, 1'b0, 1'b1, 13'h1FFE});
    chk(dm(16'h1FFE), 32'h0080);
    chk(wa(0), 32'h0080);
  endtask

  task automatic s_and_lit();
    wr(`A_FLAGS, 32'h105);
    wr(wa(1), 32'hFFFF);
    wr(`A_INSTR, {8'h0, `OPC_ANDL, 1'b0, 10'h333, 4'h1});
    chk(wa(1), 32'h0333);
    wr(wa(7), 32'h12C0);
    // Byte literal kept within 0 to 255
    wr(`A_INSTR, {8'h0, `OPC_ANDL, 1'b1, 10'h083, 4'h7});
    chk(wa(7), 32'h1280);
    chk(`A_FLAGS, 32'h10D);
    wr(wa(4), 32'hFC00);
    wr(`A_INSTR, {8'h0, `OPC_ANDL, 1'b0, 10'h3FF, 4'h4});
    chk(wa(4), 32'h0);
    chk(`A_FLAGS, 32'h107);
  endtask

  task automatic s_and_short();
    wr(wa(0), 32'h6723);
    wr(wa(5), 32'h1002);
    wr(`A_INSTR, ins(`OPC_ANDW, 0, 0, 4, 5, 7, 15));
    chk(dm(16'h1000), 32'h0003);
    chk(wa(5), 32'h1000);
    wr(wa(1), 32'h7878);
    wr(`A_INSTR, ins(`OPC_ANDW, 0, 1, 0, 1, 7, 15));
    chk(wa(1), 32'h7803);
  endtask

  task automatic s_and_reg();
    wr(wa(0), 32'hAA55);
    wr(wa(1), 32'h1000);
    wr(dm(16'h1000), 32'h2634);
    wr(`A_INSTR, ins(`OPC_ANDW, 0, 0, 0, 2, 3, 1));
    chk(wa(2), 32'h2214);
    chk(wa(1), 32'h1002);
    wr(wa(1), 32'h2211);
    wr(wa(2), 32'h1001);
    wr(dm(16'h1000), 32'hFFFF);
    wr(`A_INSTR, ins(`OPC_ANDW, 0, 1, 3, 2, 0, 1));
    chk(dm(16'h1000), 32'h11FF);
    chk(wa(2), 32'h1002);
    wr(wa(1), 32'h1002);
    wr(wa(3), 32'h0800);
    wr(dm(16'h1000), 32'h2634);
    wr(`A_INSTR, ins(`OPC_ANDW, 0, 0, 2, 3, 4, 1));
    chk(dm(16'h0800), 32'h2214);
    chk(wa(1), 32'h1000);
    chk(wa(3), 32'h07FE);
    wr(wa(0), 32'h00FF);
    wr(`A_INSTR, ins(`OPC_ANDW, 0, 0, 5, 3, 1, 1));
    chk(dm(16'h0800), 32'h0034);
    chk(wa(3), 32'h0800);
    chk(wa(1), 32'h1000);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    s_reset();
    s_carry_flags();
    s_carry_byte();
    s_carry_short();
    s_illegal();
    s_and_file();
    s_and_lit();
    s_and_short();
    s_and_reg();
    tally_and_finish();
  end
endmodule
